// *** design/tsv_defs.vh ***
// Shared constants for the transaction server: control block layout, fields, bus map.
`ifndef TSV_DEFS_VH
`define TSV_DEFS_VH
// Control block byte offsets from the rounded vector.
`define TSV_CB_COUNT 3'h0
`define TSV_CB_CTRL 3'h1
`define TSV_CB_SRC_LO 3'h2
`define TSV_CB_SRC_HI 3'h3
`define TSV_CB_DST_LO 3'h4
`define TSV_CB_DST_HI 3'h5
`define TSV_CB_BURST 3'h6
// Quad-word alignment mask for the control block address.
`define TSV_QUAD_MASK 16'hfff8
// Transfer control byte fields.
`define TSV_MODE_HI 7
`define TSV_MODE_LO 5
`define TSV_BIT_BYTE 4
`define TSV_BIT_SU 3
`define TSV_BIT_DU 2
`define TSV_BIT_SI 1
`define TSV_BIT_DI 0
`define TSV_MODE_BLOCK 3'h0
`define TSV_MODE_SINGLE 3'h4
`define TSV_MAX_BURST 8'h20
// Internal address map bounds; everything else is external space.
`define TSV_REG_RAM_END 16'h0200
`define TSV_CODE_RAM_LO 16'h0400
`define TSV_CODE_RAM_END 16'h0500
`define TSV_SFR_LO 16'h1f00
`define TSV_SFR_END 16'h2000
// Avalon register word offsets (byte address bits [5:2]).
`define TSV_REG_ENABLE 4'h0
`define TSV_REG_SELECT 4'h1
`define TSV_REG_DONE 4'h2
`define TSV_REG_STATUS 4'h3
`define TSV_REG_VEC_BASE 4'h8
`define TSV_NSRC 16
`endif

// *** design/tsv_vec_ram.v ***
// Vector table memory: one control block address per interrupt source.
`timescale 1ns/1ps
module tsv_vec_ram (
  // Clock.
  input wire clock,
  // Write port.
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [15:0] wr_data,
  // Registered read port.
  input wire [3:0] rd_addr,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:15];
  // Write when enabled, read through a register every cycle.
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // tsv_vec_ram

// *** design/tsv_prio.v ***
// Fixed priority picker: highest numbered pending source wins.
`timescale 1ns/1ps
module tsv_prio (
  // Request vector.
  input wire [15:0] req,
  // Result.
  output reg any,
  output reg [3:0] idx
);
  integer i;
  // Later iterations overwrite, so the highest index wins.
  always @* begin
    any = 1'b0;
    idx = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[3:0];
      end
    end
  end
endmodule // tsv_prio

// *** design/tsv_server.v ***
// Interrupt-driven transaction server that runs control blocks over a memory bus.
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tsv_defs.vh"
module tsv_server (
  // Clock, reset and enable.
  input wire clock,
  input wire srst,
  input wire clk_en,
  // Avalon-MM register slave.
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Interrupt requests from sources, one-cycle pulses.
  input wire [15:0] irq_in,
  // Byte-wide memory bus master.
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_ext,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  // Normal software interrupt to the core.
  output reg sw_irq,
  output reg [3:0] sw_irq_src,
  input wire sw_irq_ack,
  // Busy flag.
  output reg busy
);
  localparam S_IDLE = 4'h0;
  localparam S_VEC = 4'h1;
  localparam S_CB = 4'h2;
  localparam S_RD = 4'h3;
  localparam S_WR = 4'h4;
  localparam S_STEP = 4'h5;
  localparam S_WB = 4'h6;
  localparam S_DONE = 4'h7;
  localparam S_VWAIT = 4'h8;

  // External space: everything outside register file, code RAM and SFRs.
  function is_ext;
    input [15:0] a;
    begin
      is_ext = !((a < `TSV_REG_RAM_END) ||
                 (a >= `TSV_CODE_RAM_LO && a < `TSV_CODE_RAM_END) ||
                 (a >= `TSV_SFR_LO && a < `TSV_SFR_END));
    end
  endfunction

  reg [3:0] st_q;
  reg gen_q;
  reg [15:0] sel_q;
  reg [15:0] done_q;
  reg [15:0] pend_q;
  reg [3:0] src_q;
  reg [15:0] cb_q;
  reg [2:0] idx_q;
  reg [7:0] cnt_q;
  reg [7:0] ctl_q;
  reg [15:0] sp_q;
  reg [15:0] dp_q;
  reg [7:0] bst_q;
  reg [7:0] left_q;
  reg [15:0] dat_q;
  reg hb_q;
  reg vwr_q;
  reg [3:0] vwa_q;
  reg [15:0] vwd_q;
  wire [15:0] vec_rd;
  wire p_any;
  wire [3:0] p_idx;
  wire [15:0] done_pend;
  wire d_any;
  wire [3:0] d_idx;
  wire byte_m = ctl_q[`TSV_BIT_BYTE];
  wire [2:0] mode = ctl_q[`TSV_MODE_HI:`TSV_MODE_LO];
  wire [15:0] step = byte_m ? 16'h0001 : 16'h0002;
  // Requests of unselected sources, or with the server off, belong to software.
  wire [15:0] irq_sel = irq_in & sel_q & {16{gen_q}};

  tsv_vec_ram u_vec (
    .clock(clock),
    .wr_en(vwr_q && clk_en),
    .wr_addr(vwa_q),
    .wr_data(vwd_q),
    .rd_addr(src_q),
    .rd_data(vec_rd)
  );
  // Only selected sources with the global enable reach the server.
  tsv_prio u_prio (
    .req(pend_q & sel_q & {16{gen_q}}),
    .any(p_any),
    .idx(p_idx)
  );
  assign done_pend = done_q;
  tsv_prio u_dprio (
    .req(done_pend),
    .any(d_any),
    .idx(d_idx)
  );

  // Register slave: one wait cycle on every access, then answer.
  always @(posedge clock) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      vwr_q <= 1'b0;
      vwa_q <= 4'h0;
      vwd_q <= 16'h0000;
    end else if (clk_en) begin
      vwr_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        if (avs_read) begin
          case (avs_address[5:2])
            `TSV_REG_ENABLE: avs_readdata <= {31'h0, gen_q};
            `TSV_REG_SELECT: avs_readdata <= {16'h0000, sel_q};
            `TSV_REG_DONE: avs_readdata <= {16'h0000, done_q};
            `TSV_REG_STATUS: avs_readdata <= {23'h0, busy, src_q, st_q};
            default: avs_readdata <= 32'h0000_0000;
          endcase
        end else if (avs_address[5]) begin
          vwr_q <= 1'b1;
          vwa_q <= {avs_address[4:2], 1'b0} | {3'h0, 1'b0};
          vwd_q <= avs_writedata[15:0];
        end
      end
    end
  end

  // Software interrupt output: highest pending done flag by priority order.
  always @(posedge clock) begin
    if (srst) begin
      sw_irq <= 1'b0;
      sw_irq_src <= 4'h0;
    end else if (clk_en) begin
      sw_irq <= d_any;
      sw_irq_src <= d_idx;
    end
  end

  // Server engine with its control and status state.
  always @(posedge clock) begin
    if (srst) begin
      st_q <= S_IDLE;
      gen_q <= 1'b0;
      sel_q <= 16'h0000;
      done_q <= 16'h0000;
      pend_q <= 16'h0000;
      src_q <= 4'h0;
      cb_q <= 16'h0000;
      idx_q <= 3'h0;
      cnt_q <= 8'h00;
      ctl_q <= 8'h00;
      sp_q <= 16'h0000;
      dp_q <= 16'h0000;
      bst_q <= 8'h00;
      left_q <= 8'h00;
      dat_q <= 16'h0000;
      hb_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_ext <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      // Software writes to enable, select and done registers.
      if (avs_write && avs_waitrequest && !avs_address[5]) begin
        case (avs_address[5:2])
          `TSV_REG_ENABLE: gen_q <= avs_writedata[0];
          `TSV_REG_SELECT: sel_q <= avs_writedata[15:0];
          `TSV_REG_DONE: done_q <= done_q & ~avs_writedata[15:0];
          default: gen_q <= gen_q;
        endcase
      end
      if (sw_irq_ack) begin
        done_q[sw_irq_src] <= 1'b0;
      end
      // New requests latch; a request never gets lost while a cycle runs.
      pend_q <= pend_q | irq_sel;
      case (st_q)
        S_IDLE: begin
          busy <= 1'b0;
          if (p_any) begin
            src_q <= p_idx;
            pend_q <= (pend_q & ~(16'h0001 << p_idx)) | irq_sel;
            busy <= 1'b1;
            st_q <= S_VWAIT;
          end
        end
        S_VWAIT: st_q <= S_VEC;
        S_VEC: begin
          cb_q <= vec_rd & `TSV_QUAD_MASK;
          idx_q <= `TSV_CB_COUNT;
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_addr <= vec_rd & `TSV_QUAD_MASK;
          mem_ext <= 1'b0;
          st_q <= S_CB;
        end
        S_CB: begin
          // Each block byte is its own request, with one idle cycle between.
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= cb_q + {13'h0000, idx_q};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            case (idx_q)
              `TSV_CB_COUNT: cnt_q <= mem_rdata;
              `TSV_CB_CTRL: ctl_q <= mem_rdata;
              `TSV_CB_SRC_LO: sp_q[7:0] <= mem_rdata;
              `TSV_CB_SRC_HI: sp_q[15:8] <= mem_rdata;
              `TSV_CB_DST_LO: dp_q[7:0] <= mem_rdata;
              `TSV_CB_DST_HI: dp_q[15:8] <= mem_rdata;
              default: bst_q <= mem_rdata;
            endcase
            if (idx_q == `TSV_CB_BURST ||
                (idx_q == `TSV_CB_DST_HI && ctl_q[`TSV_MODE_HI:`TSV_MODE_LO]
                 != `TSV_MODE_BLOCK)) begin
              // Single mode moves one item; block mode its burst, capped.
              if (mode == `TSV_MODE_SINGLE || idx_q != `TSV_CB_BURST) begin
                left_q <= 8'h01;
              end else if (mem_rdata > `TSV_MAX_BURST) begin
                left_q <= `TSV_MAX_BURST;
              end else begin
                left_q <= mem_rdata;
              end
              hb_q <= 1'b0;
              st_q <= S_RD;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
        end
        S_RD: begin
          if (left_q == 8'h00) begin
            st_q <= S_WB; // zero burst moves nothing.
            idx_q <= `TSV_CB_SRC_LO;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= sp_q + {15'h0000, hb_q};
            mem_ext <= is_ext(sp_q + {15'h0000, hb_q});
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (hb_q) dat_q[15:8] <= mem_rdata;
            else dat_q[7:0] <= mem_rdata;
            if (byte_m || hb_q) begin
              hb_q <= 1'b0;
              st_q <= S_WR;
            end else begin
              hb_q <= 1'b1;
            end
          end
        end
        S_WR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= dp_q + {15'h0000, hb_q};
            mem_wdata <= hb_q ? dat_q[15:8] : dat_q[7:0];
            mem_ext <= is_ext(dp_q + {15'h0000, hb_q});
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            if (byte_m || hb_q) begin
              hb_q <= 1'b0;
              st_q <= S_STEP;
            end else begin
              hb_q <= 1'b1;
            end
          end
        end
        S_STEP: begin
          // Increments follow the destination write.
          if (ctl_q[`TSV_BIT_SI]) sp_q <= sp_q + step;
          if (ctl_q[`TSV_BIT_DI]) dp_q <= dp_q + step;
          left_q <= left_q - 8'h01;
          idx_q <= `TSV_CB_SRC_LO;
          st_q <= (left_q == 8'h01) ? S_WB : S_RD;
        end
        S_WB: begin
          // Write-back of pointers only for set update bits, then countdown.
          if (!mem_req) begin
            if (idx_q == `TSV_CB_SRC_LO && !ctl_q[`TSV_BIT_SU]) begin
              idx_q <= `TSV_CB_DST_LO;
            end else if (idx_q == `TSV_CB_DST_LO && !ctl_q[`TSV_BIT_DU]) begin
              idx_q <= `TSV_CB_COUNT;
            end else begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_ext <= 1'b0;
              mem_addr <= cb_q + {13'h0000, idx_q};
              case (idx_q)
                `TSV_CB_SRC_LO: mem_wdata <= sp_q[7:0];
                `TSV_CB_SRC_HI: mem_wdata <= sp_q[15:8];
                `TSV_CB_DST_LO: mem_wdata <= dp_q[7:0];
                `TSV_CB_DST_HI: mem_wdata <= dp_q[15:8];
                default: mem_wdata <= cnt_q - 8'h01;
              endcase
            end
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            case (idx_q)
              `TSV_CB_SRC_LO: idx_q <= `TSV_CB_SRC_HI;
              `TSV_CB_SRC_HI: idx_q <= `TSV_CB_DST_LO;
              `TSV_CB_DST_LO: idx_q <= `TSV_CB_DST_HI;
              `TSV_CB_DST_HI: idx_q <= `TSV_CB_COUNT;
              default: st_q <= S_DONE;
            endcase
          end
        end
        S_DONE: begin
          if (cnt_q == 8'h01) begin
            sel_q[src_q] <= 1'b0;
            done_q[src_q] <= 1'b1;
          end
          busy <= 1'b0;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // tsv_server

// *** verif/tsv_mem_model.sv ***
// Behavioural memory bus partner that answers promptly or slowly.
`timescale 1ns/1ps
module tsv_mem_model (
  // Clock and pace.
  input wire clock,
  input wire slow,
  // Memory bus.
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  output reg mem_ack,
  output reg [7:0] mem_rdata
);
  reg [7:0] mem [0:65535];
  reg [1:0] wait_q;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    wait_q = 2'h0;
  end
  // One ack pulse per request; read data is scrambled outside the answer cycle.
  always @(posedge clock) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= 2'h0;
    end else if (mem_req && (!slow || wait_q == 2'h3)) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr];
      end
    end else if (mem_req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule // tsv_mem_model

// *** verif/tsv_server_asserts.sv ***
// Port checker for the transaction server.
`timescale 1ns/1ps
module tsv_server_asserts (
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Register bus.
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Memory bus and status.
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire mem_ext,
  input wire mem_ack,
  input wire busy
);
  reg last_we_q;
  reg [2:0] last_lo_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Internal space is register RAM, code RAM and the upper SFR page.
  function automatic logic is_ext(input logic [15:0] a);
    is_ext = !(a < 16'h0200 || (a >= 16'h0400 && a < 16'h0500) || a >= 16'h1f00 && a < 16'h2000);
  endfunction
  // Remembers kind and block offset of the latest finished memory access.
  always @(posedge clock) begin
    if (mem_req && mem_ack) begin
      last_we_q <= mem_we;
      last_lo_q <= mem_addr[2:0];
    end
  end
  property p_reg_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_reg_answer: assert property (p_reg_answer) else $error("register answer late");
  property p_reg_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_reg_once: assert property (p_reg_once) else $error("waitrequest low too long");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request not held");
  property p_mem_drop;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("memory request not dropped");
  property p_mem_ext;
    mem_req |-> mem_ext == is_ext(mem_addr);
  endproperty
  a_mem_ext: assert property (p_mem_ext) else $error("external flag wrong");
  property p_busy_mem;
    mem_req |-> busy;
  endproperty
  a_busy_mem: assert property (p_busy_mem) else $error("memory access while idle");
  property p_end_count;
    $fell(busy) |-> last_we_q && last_lo_q == 3'h0;
  endproperty
  a_end_count: assert property (p_end_count) else $error("cycle not closed by count");
  property p_reset;
    @(posedge clock) disable iff (1'b0) srst |=> avs_waitrequest && !busy && !mem_req;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  c_done: cover property ($fell(busy));
  c_ext: cover property (mem_req && mem_ext);
  c_slow: cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
endmodule // tsv_server_asserts
bind tsv_server tsv_server_asserts u_tsv_server_asserts (.clock(clock), .srst(srst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ext(mem_ext),
  .mem_ack(mem_ack), .busy(busy));

// *** verif/tsv_server_tb.sv ***
// Self-checking bench for the transaction server.
`timescale 1ns/1ps
module tsv_server_tb;
  reg clock, srst, clk_en, avs_read, avs_write, sw_irq_ack, slow;
  reg [5:0] avs_address;
  reg [31:0] avs_writedata;
  reg [15:0] irq_in;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, mem_req, mem_we, mem_ext, mem_ack, sw_irq, busy;
  wire [15:0] mem_addr;
  wire [7:0] mem_wdata, mem_rdata;
  wire [3:0] sw_irq_src;
  int n_fail, checks;
  logic [31:0] q;
  tsv_server u_tsv_server (.clock(clock), .srst(srst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_in(irq_in), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ext(mem_ext),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .sw_irq(sw_irq), .sw_irq_src(sw_irq_src),
    .sw_irq_ack(sw_irq_ack), .busy(busy));
  tsv_mem_model u_tsv_mem_model (.clock(clock), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One register access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      test_done;
    end
  endtask
  // Pulses a source request, then waits for the server cycle to finish.
  task automatic fire(input int s);
    int n;
    n = 0;
    @(posedge clock);
    irq_in <= 16'h0001 << s;
    @(posedge clock);
    irq_in <= 16'h0000;
    repeat (4) @(posedge clock);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      test_done;
    end
  endtask
  // Loads a control block at the quad-aligned address 0100h.
  task automatic blk(input logic [7:0] c, t, input logic [15:0] s, d, input logic [7:0] b);
    u_tsv_mem_model.mem[16'h0100] = c;
    u_tsv_mem_model.mem[16'h0101] = t;
    {u_tsv_mem_model.mem[16'h0103], u_tsv_mem_model.mem[16'h0102]} = s;
    {u_tsv_mem_model.mem[16'h0105], u_tsv_mem_model.mem[16'h0104]} = d;
    u_tsv_mem_model.mem[16'h0106] = b;
  endtask
  function automatic logic [15:0] w16(input logic [15:0] a);
    return {u_tsv_mem_model.mem[a + 16'h0001], u_tsv_mem_model.mem[a]};
  endfunction
  task automatic t_regs;
    bus(0, 6'h00, 0);
    chk("enable", 0, q);
    bus(0, 6'h04, 0);
    chk("select", 0, q);
    bus(0, 6'h10, 0);
    chk("unmapped", 0, q);
    bus(0, 6'h0c, 0);
    chk("status", 0, q);
    bus(1, 6'h00, 32'h0000_0001);
    bus(0, 6'h00, 0);
    chk("enable", 1, q);
    bus(1, 6'h20, 32'h0000_0103);
  endtask
  task automatic t_single;
    blk(8'h02, 8'h9a, 16'h0400, 16'h0600, 8'h00);
    u_tsv_mem_model.mem[16'h0400] = 8'ha5;
    u_tsv_mem_model.mem[16'h0401] = 8'h3c;
    u_tsv_mem_model.mem[16'h0601] = 8'h77;
    bus(1, 6'h04, 32'h0000_0001);
    fire(0);
    chk("dst byte", 8'ha5, u_tsv_mem_model.mem[16'h0600]);
    chk("src ptr", 16'h0401, w16(16'h0102));
    chk("count", 1, u_tsv_mem_model.mem[16'h0100]);
    fire(0);
    chk("dst byte", 8'h3c, u_tsv_mem_model.mem[16'h0600]);
    chk("dst next", 8'h77, u_tsv_mem_model.mem[16'h0601]);
    chk("dst ptr", 16'h0600, w16(16'h0104));
    chk("count", 0, u_tsv_mem_model.mem[16'h0100]);
    bus(0, 6'h04, 0);
    chk("select", 0, q);
    bus(0, 6'h08, 0);
    chk("done", 1, q);
    chk("sw_irq", 1, sw_irq);
    chk("sw_irq_src", 0, sw_irq_src);
    @(posedge clock);
    sw_irq_ack <= 1'b1;
    @(posedge clock);
    sw_irq_ack <= 1'b0;
    bus(0, 6'h08, 0);
    chk("done", 0, q);
  endtask
  task automatic t_block;
    slow <= 1'b1;
    blk(8'h01, 8'h0b, 16'h0410, 16'h0620, 8'h02);
    {u_tsv_mem_model.mem[16'h0411], u_tsv_mem_model.mem[16'h0410]} = 16'h2211;
    {u_tsv_mem_model.mem[16'h0413], u_tsv_mem_model.mem[16'h0412]} = 16'h4433;
    u_tsv_mem_model.mem[16'h0624] = 8'h55;
    bus(1, 6'h04, 32'h0000_0001);
    fire(0);
    chk("dst word0", 16'h2211, w16(16'h0620));
    chk("dst word1", 16'h4433, w16(16'h0622));
    chk("dst after", 8'h55, u_tsv_mem_model.mem[16'h0624]);
    chk("src ptr", 16'h0414, w16(16'h0102));
    chk("dst ptr", 16'h0620, w16(16'h0104));
    bus(0, 6'h08, 0);
    chk("done", 1, q);
    bus(1, 6'h08, 32'h0000_0001);
    bus(0, 6'h08, 0);
    chk("done", 0, q);
    slow <= 1'b0;
  endtask
  task automatic t_off;
    bus(1, 6'h00, 0);
    blk(8'h05, 8'h9a, 16'h0400, 16'h0600, 8'h00);
    bus(1, 6'h04, 32'h0000_0001);
    fire(0);
    chk("count", 5, u_tsv_mem_model.mem[16'h0100]);
    bus(1, 6'h00, 32'h0000_0001);
    repeat (20) @(posedge clock);
    chk("busy", 0, busy);
    chk("stale count", 5, u_tsv_mem_model.mem[16'h0100]);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Reset, then run every scenario in turn.
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    irq_in = 16'h0000;
    sw_irq_ack = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    t_regs;
    t_single;
    t_block;
    t_off;
    test_done;
  end
endmodule // tsv_server_tb
